//--- ptdiv_top.sv
// Purpose : Periodic tick divider with APB register access and interrupt
// Assumes : Source clocks and mode inputs are synchronous to pclk
// Notes   : Zero-wait APB slave; unmapped or unaligned access gives pslverr
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ptdiv_cfg.svh"
module ptdiv_top #(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 22
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              internal_reference_clock,
    input  wire logic              external_oscillator_clock,
    input  wire logic              oscillator_up_status,
    input  wire logic              stop_mode,
    output logic                   periodic_tick_irq
);

    // ==========================================================
    // Register decode
    // Word-aligned map, one register per word
    // Index is the byte address shifted by two
    // Low address bits nonzero: access fails
    // Failed access: pslverr in access cycle only
    // Failed access changes no register
    // Status and count ignore writes, no error
    // Clear register reads back as zero
    // Only byte lane 0 carries writable register data
    // Strobe bit 0 low: write is dropped
    // Upper data bits read as zero
    // No wait states: pready tied high
    // Access phase always one cycle
    // Back-to-back transfers allowed
    // Decode is pure logic on paddr
    // Same decode feeds read and write
    // Hazard: paddr must hold through access

    // Map a byte address to a register; shared by read and write paths
    function automatic ptdiv_pkg::ptdiv_reg_t ptdiv_decode(input logic [ADDR_W-1:0] a);
        ptdiv_pkg::ptdiv_reg_t r;
        r = ptdiv_pkg::PTDIV_R_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[ADDR_W-1:2])
                `PTDIV_IDX_RATE:   r = ptdiv_pkg::PTDIV_R_RATE;
                `PTDIV_IDX_STATUS: r = ptdiv_pkg::PTDIV_R_STATUS;
                `PTDIV_IDX_CLEAR:  r = ptdiv_pkg::PTDIV_R_CLEAR;
                `PTDIV_IDX_ENABLE: r = ptdiv_pkg::PTDIV_R_ENABLE;
                `PTDIV_IDX_CLKSEL: r = ptdiv_pkg::PTDIV_R_CLKSEL;
                `PTDIV_IDX_COUNT:  r = ptdiv_pkg::PTDIV_R_COUNT;
                default:           r = ptdiv_pkg::PTDIV_R_NONE;
            endcase
        end
        return r;
    endfunction : ptdiv_decode

    ptdiv_pkg::ptdiv_reg_t  reg_sel;
    logic                   setup_phase;
    logic                   access_phase;
    logic                   wr_access;
    logic                   low_lane;

    // Bus phases; writes land only in the access phase
    assign reg_sel      = ptdiv_decode(paddr);
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access    = access_phase && pwrite;
    // All writable registers are one byte wide and live in lane 0
    assign low_lane     = pstrb[0];

    // ==========================================================
    // Register state
    // Rate: decimal, prescale, modulus
    // Any accepted rate write restarts
    // Even a same-value write restarts
    // Clock select: source and pseudo-stop
    // Source forced low, oscillator down
    // Write of one ignored in that case
    // Forcing beats a write in one edge
    // Pseudo-stop bit is plain storage
    // Enable mask shares status layout
    // Bit 0 tick, bit 1 oscillator loss
    // Writes land only in access phase
    // Setup phase changes no state
    // Rate resets to binary off
    // Software disables with that value
    // All reset values are constants
    // Limitation: no write protection

    ptdiv_pkg::ptdiv_rate_t rate_ff;
    ptdiv_pkg::ptdiv_clk_t  clk_ff;
    logic [1:0]             enable_ff;
    logic [1:0]             status_ff;
    logic [1:0]             nxt_status;
    logic                   rate_wr;
    logic                   clksel_wr;
    logic                   clear_wr;
    logic                   enable_wr;

    assign rate_wr   = wr_access && low_lane && (reg_sel == ptdiv_pkg::PTDIV_R_RATE);
    assign clksel_wr = wr_access && low_lane && (reg_sel == ptdiv_pkg::PTDIV_R_CLKSEL);
    assign clear_wr  = wr_access && low_lane && (reg_sel == ptdiv_pkg::PTDIV_R_CLEAR);
    assign enable_wr = wr_access && low_lane && (reg_sel == ptdiv_pkg::PTDIV_R_ENABLE);

    // Tick rate control, writable at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_ff <= ptdiv_pkg::ptdiv_rate_t'(`PTDIV_RATE_RST);
        end else if (rate_wr) begin
            rate_ff <= ptdiv_pkg::ptdiv_rate_t'(pwdata[7:0]);
        end
    end

    // Clock select and pseudo-stop controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_ff <= '0;
        end else begin
            if (clksel_wr) begin
                clk_ff.pseudo_stop <= pwdata[`PTDIV_PSEUDO_BIT];
            end
            // Oscillator loss wins over any write that tries to set it
            if (!oscillator_up_status) begin
                clk_ff.osc_select <= 1'b0;
            end else if (clksel_wr) begin
                clk_ff.osc_select <= pwdata[`PTDIV_SEL_BIT];
            end
        end
    end

    // Interrupt enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= `PTDIV_EVT_RST;
        end else if (enable_wr) begin
            enable_ff <= pwdata[1:0];
        end
    end

    // ==========================================================
    // Restart detection
    // Two causes of a fresh period
    // One: any accepted rate write
    // Two: the source select changes
    // Select change seen one edge late
    // Stored copy of select is compared
    // Covers writes and forced clears
    // Same-value select write: no change
    // Restart clears the count
    // Restart beats counting
    // Period end in restart edge dropped
    // Trade-off: one edge of latency
    // Buys a compare of two flops only
    // No combinational path from bus
    // Copy resets like the select
    // So reset gives no false restart
    // Status flags untouched by restart

    logic sel_seen_ff;
    logic sel_changed;
    logic restart;

    // Last select value the counter has seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_seen_ff <= 1'b0;
        end else begin
            sel_seen_ff <= clk_ff.osc_select;
        end
    end

    // Writing the same select value is no change and no restart
    assign sel_changed = sel_seen_ff != clk_ff.osc_select;
    assign restart     = rate_wr || sel_changed;

    // ==========================================================
    // Divider
    // Counts rises of the chosen source
    // Internal reference at select 0
    // Oscillator at select 1
    // Sources are levels sampled at pclk
    // Limitation: source under half pclk
    // Ratio: prescale times modulus plus one
    // Binary prescale zero: generator off
    // Off holds the count at zero
    // Decimal family has no off code
    // Stop mode halts the count
    // Except pseudo-stop on oscillator
    // Halted count keeps its value
    // Counting resumes from that value
    // Last edge of period wraps to zero
    // Wrap needs no software action
    // Width covers the largest ratio

    logic [CNT_W-1:0] ratio;
    logic             gen_off;
    logic             src_edge;
    logic             run;
    logic             period_end;
    logic [CNT_W-1:0] cnt_ff;

    ptdiv_ratio #(
        .CNT_W (CNT_W)
    ) u_ratio (
        .rate  (rate_ff),
        .ratio (ratio),
        .off   (gen_off)
    );

    ptdiv_src_edge u_src (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .internal_reference_clock  (internal_reference_clock),
        .external_oscillator_clock (external_oscillator_clock),
        .osc_select                (clk_ff.osc_select),
        .src_edge                  (src_edge)
    );

    // Stop mode freezes the count unless pseudo-stop runs the oscillator
    assign run = !stop_mode || (clk_ff.pseudo_stop && clk_ff.osc_select);

    // Last source edge of the period
    assign period_end = run && src_edge && !gen_off && (cnt_ff == ratio - CNT_W'(1));

    // Tick counter; a restart takes priority over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (restart || gen_off) begin
            cnt_ff <= '0;
        end else if (period_end) begin
            cnt_ff <= '0;
        end else if (run && src_edge) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
        // When not running nothing is assigned: the count is held
    end

    // ==========================================================
    // Events and interrupt
    // Two sticky status flags
    // Tick flag set at period end
    // Loss flag set as select is forced
    // Loss stands one cycle at most
    // Next edge the select is low
    // Flags clear by writing ones
    // Clear acts bit by bit
    // Zero bits in a clear do nothing
    // Event and clear together: event wins
    // Avoids a tick lost to a clear race
    // Mask gates the interrupt only
    // Flags set enabled or not
    // Interrupt is a level
    // High while an enabled flag stands
    // Drops once the flag is cleared
    // Driven from registers only

    logic [1:0] events;
    logic       osc_lost;

    // Oscillator loss that drops an active select
    assign osc_lost = clk_ff.osc_select && !oscillator_up_status;

    // A fresh write restarts before the old period could complete
    assign events[`PTDIV_TICK_BIT] = period_end && !restart;
    assign events[`PTDIV_LOST_BIT] = osc_lost;

    // Sticky status; a new event beats a clear in the same cycle
    always_comb begin
        nxt_status = status_ff;
        if (clear_wr) begin
            nxt_status = status_ff & ~pwdata[1:0];
        end
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `PTDIV_EVT_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Level interrupt while an enabled flag stands
    assign periodic_tick_irq = |(status_ff & enable_ff);

    // ==========================================================
    // Read path
    // One mux for all readable registers
    // Mux follows the decoded select
    // Value taken at the setup edge
    // Access shows a registered value
    // Held until the next read setup
    // Writes never disturb it
    // Trade-off: value one edge old
    // Count may move by one meanwhile
    // Unmapped reads zero with pslverr
    // Count read gives full width
    // Clock select shows both bits
    // Other bits of that word zero
    // Rate read shows the stored byte
    // Status read shows both flags
    // Enable read shows the mask
    // Handshake outputs combinational

    logic [31:0] rd_value;
    logic [31:0] prdata_ff;

    // Read mux; clear register is write-only and reads zero
    always_comb begin
        rd_value = 32'h0000_0000;
        case (reg_sel)
            ptdiv_pkg::PTDIV_R_RATE:   rd_value = {24'h00_0000, rate_ff};
            ptdiv_pkg::PTDIV_R_STATUS: rd_value = {30'h0000_0000, status_ff};
            ptdiv_pkg::PTDIV_R_ENABLE: rd_value = {30'h0000_0000, enable_ff};
            ptdiv_pkg::PTDIV_R_CLKSEL: begin
                rd_value[`PTDIV_PSEUDO_BIT] = clk_ff.pseudo_stop;
                rd_value[`PTDIV_SEL_BIT]  = clk_ff.osc_select;
            end
            ptdiv_pkg::PTDIV_R_COUNT:  rd_value = 32'(cnt_ff);
            default:                   rd_value = 32'h0000_0000;
        endcase
    end

    // Captured in setup so the access phase presents a registered value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_ff <= rd_value;
        end
    end

    assign prdata  = prdata_ff;
    // Zero wait states keep software timing simple
    assign pready  = 1'b1;
    assign pslverr = access_phase && (reg_sel == ptdiv_pkg::PTDIV_R_NONE);

endmodule : ptdiv_top

//--- ptdiv_cfg.svh
// Purpose : Constants of the periodic tick divider (offsets, fields, resets)
// Assumes : Included by bare name from every design file that needs it
// Notes   : Register byte address is four times the register index
`ifndef PTDIV_CFG_SVH
`define PTDIV_CFG_SVH

// ==========================================================
// Register indexes
`define PTDIV_IDX_RATE      10'h03B
`define PTDIV_IDX_STATUS    10'h040
`define PTDIV_IDX_CLEAR     10'h041
`define PTDIV_IDX_ENABLE    10'h042
`define PTDIV_IDX_CLKSEL    10'h043
`define PTDIV_IDX_COUNT     10'h044

// ==========================================================
// Field positions
`define PTDIV_DEC_BIT       7
`define PTDIV_PRE_MSB       6
`define PTDIV_PRE_LSB       4
`define PTDIV_MOD_MSB       3
`define PTDIV_MOD_LSB       0
`define PTDIV_SEL_BIT       1
`define PTDIV_PSEUDO_BIT    6
`define PTDIV_TICK_BIT      0
`define PTDIV_LOST_BIT      1

// ==========================================================
// Reset values
`define PTDIV_RATE_RST      8'h00
`define PTDIV_CLKSEL_RST    8'h00
`define PTDIV_EVT_RST       2'h0

// ==========================================================
// Prescale values
`define PTDIV_BIN_EXP_BASE  9
`define PTDIV_DEC_PRE0      1000
`define PTDIV_DEC_PRE1      2000
`define PTDIV_DEC_PRE2      5000
`define PTDIV_DEC_PRE3      10000
`define PTDIV_DEC_PRE4      20000
`define PTDIV_DEC_PRE5      50000
`define PTDIV_DEC_PRE6      100000
`define PTDIV_DEC_PRE7      200000

`endif

//--- ptdiv_pkg.sv
// Purpose : Shared types of the periodic tick divider
// Assumes : Rate field layout matches ptdiv_cfg.svh
// Notes   : Used by name only, never imported
package ptdiv_pkg;

    // Tick rate control layout
    typedef struct packed {
        logic       decimal;
        logic [2:0] prescale;
        logic [3:0] modulus;
    } ptdiv_rate_t;

    // Clock-source controls
    typedef struct packed {
        logic pseudo_stop;
        logic osc_select;
    } ptdiv_clk_t;

    // Register decode result
    typedef enum {
        PTDIV_R_RATE,
        PTDIV_R_STATUS,
        PTDIV_R_CLEAR,
        PTDIV_R_ENABLE,
        PTDIV_R_CLKSEL,
        PTDIV_R_COUNT,
        PTDIV_R_NONE
    } ptdiv_reg_t;

endpackage : ptdiv_pkg

//--- ptdiv_ratio.sv
// Purpose : Total divide ratio from the tick rate control value
// Assumes : Ratio fits in CNT_W bits
// Notes   : Pure combinational lookup
`timescale 1ns/1ps
`include "ptdiv_cfg.svh"
module ptdiv_ratio #(
    parameter int CNT_W = 22
) (
    input  wire ptdiv_pkg::ptdiv_rate_t rate,
    output logic [CNT_W-1:0] ratio,
    output logic             off
);
    // Prescale of the selected family
    function automatic logic [CNT_W-1:0] ptdiv_prescale(input ptdiv_pkg::ptdiv_rate_t r);
        logic [CNT_W-1:0] v;
        v = '0;
        if (r.decimal) begin
            case (r.prescale)
                3'h0:    v = CNT_W'(`PTDIV_DEC_PRE0);
                3'h1:    v = CNT_W'(`PTDIV_DEC_PRE1);
                3'h2:    v = CNT_W'(`PTDIV_DEC_PRE2);
                3'h3:    v = CNT_W'(`PTDIV_DEC_PRE3);
                3'h4:    v = CNT_W'(`PTDIV_DEC_PRE4);
                3'h5:    v = CNT_W'(`PTDIV_DEC_PRE5);
                3'h6:    v = CNT_W'(`PTDIV_DEC_PRE6);
                default: v = CNT_W'(`PTDIV_DEC_PRE7);
            endcase
        end else if (r.prescale != 3'h0) begin
            // Five-bit sum: code 7 needs a shift of 16
            v = CNT_W'(1) << (5'(r.prescale) + 5'(`PTDIV_BIN_EXP_BASE));
        end
        return v;
    endfunction : ptdiv_prescale

    logic [CNT_W+4:0] product;

    // Modulus multiplies prescale by value plus one
    assign product = ptdiv_prescale(rate) * ({1'b0, rate.modulus} + 5'h1);
    assign ratio   = product[CNT_W-1:0];
    assign off     = !rate.decimal && (rate.prescale == 3'h0);

endmodule : ptdiv_ratio

//--- ptdiv_src_edge.sv
// Purpose : Select the tick clock source and mark its rising edges
// Assumes : Both source clocks are levels synchronous to pclk
// Notes   : Each source keeps its own history so a switch gives no false edge
`timescale 1ns/1ps
module ptdiv_src_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic internal_reference_clock,
    input  wire logic external_oscillator_clock,
    input  wire logic osc_select,
    output logic      src_edge
);
    logic irc_prev_ff;
    logic osc_prev_ff;

    // Previous levels of both sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irc_prev_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end else begin
            irc_prev_ff <= internal_reference_clock;
            osc_prev_ff <= external_oscillator_clock;
        end
    end

    // Rising edge of the selected source
    assign src_edge = osc_select ? (external_oscillator_clock && !osc_prev_ff)
                                 : (internal_reference_clock && !irc_prev_ff);

endmodule : ptdiv_src_edge

//--- ptdiv_top_props.sv
// Purpose : Port-level checks of the periodic tick divider
// Assumes : Zero-wait APB slave, byte address four times the index
// Notes   : Shadows of software writes stand in for hidden registers
`timescale 1ns/1ps
`include "ptdiv_cfg.svh"
module ptdiv_props #(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 22
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              internal_reference_clock,
    input wire logic              external_oscillator_clock,
    input wire logic              oscillator_up_status,
    input wire logic              stop_mode,
    input wire logic              periodic_tick_irq
);
    localparam logic [ADDR_W-1:0] A_RATE = {`PTDIV_IDX_RATE, 2'b00};
    localparam logic [ADDR_W-1:0] A_EN   = {`PTDIV_IDX_ENABLE, 2'b00};
    localparam logic [ADDR_W-1:0] A_SEL  = {`PTDIV_IDX_CLKSEL, 2'b00};
    localparam logic [ADDR_W-1:0] A_CNT  = {`PTDIV_IDX_COUNT, 2'b00};
    localparam logic [ADDR_W-1:0] A_BAD  = 12'h200;
    logic [7:0] rate_sh_ff;
    logic [1:0] en_sh_ff;
    logic       acc, wr, rd;

    // ==========================================
    // Shadows of accepted writes
    assign acc = psel & penable;
    assign wr  = acc & pwrite & pstrb[0];
    assign rd  = acc & ~pwrite;
    // Rate shadow, reset to binary off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rate_sh_ff <= 8'h00;
        else if (wr && paddr == A_RATE) rate_sh_ff <= pwdata[7:0];
    end
    // Enable shadow, only the two event bits matter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en_sh_ff <= 2'h0;
        else if (wr && paddr == A_EN) en_sh_ff <= pwdata[1:0];
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY: assert property (pready) else $error("pready low");
    AST_RATE_OK: assert property (acc && paddr == A_RATE |-> !pslverr) else $error("rate access refused");
    AST_UNMAP: assert property (acc && paddr == A_BAD |-> pslverr) else $error("unmapped access accepted");
    AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("error outside access");
    AST_RATE_RD: assert property (rd && paddr == A_RATE |-> prdata == {24'h000000, rate_sh_ff})
        else $error("rate readback wrong");
    AST_OFF_HELD: assert property (rd && paddr == A_CNT && rate_sh_ff[7:4] == 4'h0 |-> prdata == 32'h0)
        else $error("counter moves while off");
    AST_SEL_FORCE: assert property (psel && !penable && !pwrite && paddr == A_SEL && !oscillator_up_status
        && !$past(oscillator_up_status) |=> !prdata[1]) else $error("select set without oscillator");
    AST_IRQ_MASK: assert property (en_sh_ff == 2'h0 |-> !periodic_tick_irq) else $error("masked irq");
    AST_IRQ_RST: assert property ($rose(presetn) |-> !periodic_tick_irq) else $error("irq after reset");
    COV_IRQ: cover property ($rose(periodic_tick_irq));
    COV_ERR: cover property (pslverr);
    COV_SEL: cover property (rd && paddr == A_SEL);
endmodule : ptdiv_props

bind ptdiv_top ptdiv_props #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_ptdiv_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_reference_clock(internal_reference_clock),
    .external_oscillator_clock(external_oscillator_clock), .oscillator_up_status(oscillator_up_status),
    .stop_mode(stop_mode), .periodic_tick_irq(periodic_tick_irq));

//--- tb_top.sv
// Purpose : Self-checking bench of the periodic tick divider
// Assumes : Source levels are sampled at pclk, one rise per two cycles
// Notes   : Ratios kept short so the run stays bounded
`timescale 1ns/1ps
`include "ptdiv_cfg.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0]  pstrb;
    logic        ref_clk, osc_clk, osc_up, stop, irq, ev;
    int          err_count, n_tests;

    ptdiv_top u_ptdiv_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_reference_clock(ref_clk), .external_oscillator_clock(osc_clk),
        .oscillator_up_status(osc_up), .stop_mode(stop), .periodic_tick_irq(irq));

    // ==========================================
    // Clock, verdict and compares
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude;
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Irq follows the registers directly; sampled at the negedge after the write lands
    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    // ==========================================
    // APB master and source stimulus
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, rv, ev);
    endtask : wr
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, rv, ev);
        chk(rv, exp);
    endtask : rdc
    // Full pulses only, so each rise is counted once
    task automatic edges(input int n, input logic on_osc);
        repeat (n) begin
            @(posedge pclk);
            if (on_osc) osc_clk <= 1'b1;
            else ref_clk <= 1'b1;
            @(posedge pclk);
            ref_clk <= 1'b0;
            osc_clk <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask : edges
    // One full period, checked just short of and at the ratio
    task automatic run(input logic [7:0] rate, input int ratio);
        wr(`PTDIV_IDX_RATE, {24'h0, rate});
        edges(ratio - 1, 1'b0);
        rdc(`PTDIV_IDX_COUNT, ratio - 1);
        rdc(`PTDIV_IDX_STATUS, 32'h0);
        edges(1, 1'b0);
        rdc(`PTDIV_IDX_STATUS, 32'h1);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        chk_irq(1'b1);
        wr(`PTDIV_IDX_CLEAR, 32'h3);
        chk_irq(1'b0);
    endtask : run

    // ==========================================
    // Main sequence and hang guard
    initial begin
        {psel, penable, pwrite, ref_clk, osc_clk, osc_up, stop, presetn} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        err_count = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`PTDIV_IDX_RATE, 32'h0);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        apb(1'b0, 10'h080, 32'h0, rv, ev);
        chk({31'h0, ev}, 32'h1);
        wr(`PTDIV_IDX_RATE, 32'h0F);
        edges(40, 1'b0);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        rdc(`PTDIV_IDX_STATUS, 32'h0);
        wr(`PTDIV_IDX_RATE, 32'h10);
        edges(100, 1'b0);
        rdc(`PTDIV_IDX_COUNT, 32'd100);
        wr(`PTDIV_IDX_RATE, 32'h10);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        edges(1024, 1'b0);
        rdc(`PTDIV_IDX_STATUS, 32'h1);
        chk_irq(1'b0);
        wr(`PTDIV_IDX_ENABLE, 32'h3);
        chk_irq(1'b1);
        wr(`PTDIV_IDX_CLEAR, 32'h1);
        chk_irq(1'b0);
        edges(30, 1'b0);
        stop <= 1'b1;
        edges(30, 1'b0);
        rdc(`PTDIV_IDX_COUNT, 32'd30);
        stop <= 1'b0;
        edges(5, 1'b0);
        rdc(`PTDIV_IDX_COUNT, 32'd35);
        wr(`PTDIV_IDX_CLKSEL, 32'h42);
        rdc(`PTDIV_IDX_CLKSEL, 32'h40);
        stop <= 1'b1;
        edges(5, 1'b0);
        rdc(`PTDIV_IDX_COUNT, 32'd35);
        osc_up <= 1'b1;
        wr(`PTDIV_IDX_CLKSEL, 32'h42);
        rdc(`PTDIV_IDX_CLKSEL, 32'h42);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        edges(20, 1'b0);
        edges(20, 1'b1);
        rdc(`PTDIV_IDX_COUNT, 32'd20);
        osc_up <= 1'b0;
        repeat (4) @(posedge pclk);
        stop <= 1'b0;
        rdc(`PTDIV_IDX_CLKSEL, 32'h40);
        rdc(`PTDIV_IDX_COUNT, 32'h0);
        rdc(`PTDIV_IDX_STATUS, 32'h2);
        wr(`PTDIV_IDX_CLEAR, 32'h3);
        chk_irq(1'b0);
        run(8'h1F, 16384);
        run(8'h20, 2048);
        run(8'h80, 1000);
        run(8'h91, 4000);
        run(8'hA0, 5000);
        conclude();
    end
    initial begin
        repeat (95000) @(posedge pclk);
        err_count++;
        conclude();
    end
endmodule : tb_top
